// ---- nvm_lock_fuse_config_regs.svh ----
// Register offsets, field positions, reset values and fixed addresses of the fuse and lock block.
// Included by the design module, the checker and the bench; holds definitions only.
`ifndef NVM_LOCK_FUSE_CONFIG_REGS_SVH
`define NVM_LOCK_FUSE_CONFIG_REGS_SVH

// APB byte offsets
`define OFS_FUSE_CONFIG_HIGH 12'h000
`define OFS_FUSE_CONFIG_LOW 12'h004
`define OFS_LOCK 12'h008
`define OFS_COMMAND 12'h00C
`define OFS_SIG_ADDR 12'h010
`define OFS_SIG_DATA 12'h014
`define OFS_OSC_TRIM 12'h018
`define OFS_STATUS 12'h01C

// High fuse byte fields
`define FH_RESET_PIN_DISABLE 7
`define FH_WATCHDOG_FORCED_ON 6
`define FH_SERIAL_PROG_ENABLE 5
`define FH_OSCILLATOR_OPTION 4
`define FH_EEPROM_PRESERVE 3
`define FH_BOOT_SIZE_HI 2
`define FH_BOOT_SIZE_LO 1
`define FH_RESET_VECTOR_SELECT 0

// Low fuse byte fields
`define FL_BROWNOUT_LEVEL 7
`define FL_BROWNOUT_ENABLE 6
`define FL_STARTUP_TIME_HI 5
`define FL_STARTUP_TIME_LO 4
`define FL_CLOCK_SOURCE_HI 3
`define FL_CLOCK_SOURCE_LO 0

// Lock byte fields
`define LK_BOOT_LOCK_HI 5
`define LK_BOOT_LOCK_LO 4
`define LK_MEMORY_LOCK_FIRST 0

// Reset values
`define FUSE_HIGH_DEFAULT 8'hD9
`define FUSE_LOW_DEFAULT 8'hE1
`define LOCK_DEFAULT 8'hFF

// Command register bits
`define CMD_CHIP_ERASE 0

// Boot section start word address per boot size code
`define BOOT_START_SZ3 12'hF80
`define BOOT_START_SZ2 12'hF00
`define BOOT_START_SZ1 12'hE00
`define BOOT_START_SZ0 12'hC00

// Signature row
`define SIG_LAST_ADDR 2'h2

// Flash and EEPROM page split
`define FLASH_WORD_MSB 4
`define FLASH_PAGE_LSB 5
`define FLASH_ADDR_MSB 11
`define EE_BYTE_MSB 1
`define EE_PAGE_LSB 2
`define EE_ADDR_MSB 8

`endif

// ---- nvm_lock_fuse_config_pkg.sv ----
// Types shared by the fuse and lock block.
// Constants stand in the _regs header.
package nvm_lock_fuse_config_pkg;

   typedef enum logic [1:0] {
      ST_NORMAL = 2'b00,
      ST_ENTER = 2'b01,
      ST_PROG = 2'b11,
      ST_EXIT = 2'b10
   } prog_state_t;

endpackage : nvm_lock_fuse_config_pkg

// ---- nvm_lock_fuse_config.sv ----
// Fuse bytes, lock byte, signature row, oscillator trim and boot lock gating of a small microcontroller.
// Assumes an APB master on pclk, CPU request strobes on pclk and programmer mode pins from outside.
//
// How it works
// - Boot locks both one: no boot restriction
// - Lock hi one, lo zero: block boot writes
// - Both zero: block boot writes, app reads
// - Hi zero, lo one: block app boot reads
// - Read locked, app vectors: mask boot interrupts
// - Programmed bits read zero, unprogrammed one
// - High fuse byte field layout
// - High fuse defaults: serial enable, boot size
// - Low fuse byte field layout
// - Low fuse defaults: start-up 10, clock 0001
// - Serial path cannot see serial enable; the status register still shows its active bit
// - Chip erase keeps both fuse bytes
// - First memory lock blocks fuse changes
// - Fuses latch on mode entry, mode exit, power-up
// - EEPROM preserve takes effect at once
// - Three identification bytes, always readable
// - Four trim values in signature high bytes
// - Reset loads 1 MHz trim value
// - Flash 128 pages of 32 words
// - EEPROM 128 pages of 4 bytes
`timescale 1ns/1ns
`include "nvm_lock_fuse_config_regs.svh"

module nvm_lock_fuse_config
   import nvm_lock_fuse_config_pkg::*;
#(
   parameter logic [7:0] SIG_BYTE0 = 8'h5A, // Arbitrary identification value
   parameter logic [7:0] SIG_BYTE1 = 8'hA5, // Arbitrary identification value
   parameter logic [7:0] SIG_BYTE2 = 8'h3C, // Arbitrary identification value
   parameter logic [7:0] CAL_1MHZ = 8'h80,
   parameter logic [7:0] CAL_2MHZ = 8'h81,
   parameter logic [7:0] CAL_4MHZ = 8'h82,
   parameter logic [7:0] CAL_8MHZ = 8'h83
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic prog_mode_pin,
   input wire logic prog_serial_pin,
   input wire logic [11:0] cpu_pc,
   input wire logic [11:0] cpu_target_addr,
   input wire logic cpu_spm_req,
   input wire logic cpu_lpm_req,
   input wire logic cpu_vectors_in_boot,
   output logic self_program_write_done,
   output logic self_program_write_ok,
   output logic program_memory_read_done,
   output logic program_memory_read_ok,
   output logic irq_block,
   output logic chip_erase_flash,
   output logic chip_erase_eeprom,
   output logic [7:0] oscillator_trim_register,
   output logic reset_pin_disable,
   output logic watchdog_forced_on,
   output logic serial_prog_enable,
   output logic oscillator_option,
   output logic eeprom_preserve,
   output logic boot_size_hi,
   output logic boot_size_lo,
   output logic reset_vector_select,
   output logic brownout_level,
   output logic brownout_enable,
   output logic startup_time_hi,
   output logic startup_time_lo,
   output logic [3:0] clock_source_select,
   input wire logic [11:0] flash_addr,
   input wire logic [8:0] eeprom_address,
   output logic [4:0] word_in_page_index,
   output logic [6:0] page_index,
   output logic [1:0] eeprom_byte_index,
   output logic [6:0] eeprom_page_index
);

   // Pin synchronisers
   logic mode_meta_q;
   logic mode_sync_q;
   logic serial_meta_q;
   logic serial_sync_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_meta_q <= 1'b0;
         mode_sync_q <= 1'b0;
         serial_meta_q <= 1'b0;
         serial_sync_q <= 1'b0;
      end else begin
         mode_meta_q <= prog_mode_pin;
         mode_sync_q <= mode_meta_q;
         serial_meta_q <= prog_serial_pin;
         serial_sync_q <= serial_meta_q;
      end
   end

   // Programming mode sequencer
   prog_state_t state_q;
   prog_state_t state_d;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_NORMAL: if (mode_sync_q) state_d = ST_ENTER;
         ST_ENTER: state_d = ST_PROG;
         ST_PROG: if (!mode_sync_q) state_d = ST_EXIT;
         ST_EXIT: state_d = ST_NORMAL;
         default: state_d = ST_NORMAL;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_NORMAL;
      end else begin
         state_q <= state_d;
      end
   end

   logic in_prog;
   assign in_prog = (state_q == ST_ENTER) || (state_q == ST_PROG);

   // APB decode; the answer comes one cycle into the access phase
   logic access;
   logic wr_en;
   logic rd_en;
   logic mapped;
   assign access = psel && penable && !pready;
   assign wr_en = access && pwrite;
   assign rd_en = access && !pwrite;

   always_comb begin
      case (paddr)
         `OFS_FUSE_CONFIG_HIGH,
         `OFS_FUSE_CONFIG_LOW,
         `OFS_LOCK,
         `OFS_COMMAND,
         `OFS_SIG_ADDR,
         `OFS_SIG_DATA,
         `OFS_OSC_TRIM,
         `OFS_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Stored bits, zero means programmed
   logic [7:0] fuse_high_q;
   logic [7:0] fuse_low_q;
   logic [7:0] lock_q;
   logic [7:0] fuse_high_act_q;
   logic [7:0] fuse_low_act_q;
   logic power_up_q;

   // Fuse writes need programming mode and an unlocked first memory lock.
   // With the reset pin disabled the serial path may no longer change fuses.
   logic fuse_wr_ok;
   assign fuse_wr_ok = in_prog
      && lock_q[`LK_MEMORY_LOCK_FIRST]
      && !(serial_sync_q && !fuse_high_q[`FH_RESET_PIN_DISABLE]);

   logic wr_fuse_high;
   logic wr_fuse_low;
   logic fuse_refused;
   assign wr_fuse_high = wr_en && (paddr == `OFS_FUSE_CONFIG_HIGH);
   assign wr_fuse_low = wr_en && (paddr == `OFS_FUSE_CONFIG_LOW);
   assign fuse_refused = (wr_fuse_high || wr_fuse_low) && !fuse_wr_ok;

   logic erase_cmd;
   assign erase_cmd = wr_en && (paddr == `OFS_COMMAND) && pwdata[`CMD_CHIP_ERASE] && in_prog;

   // Nonvolatile fuse store; chip erase has no path into it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fuse_high_q <= `FUSE_HIGH_DEFAULT;
         fuse_low_q <= `FUSE_LOW_DEFAULT;
      end else begin
         if (wr_fuse_high && fuse_wr_ok) begin
            fuse_high_q <= pwdata[7:0];
            if (serial_sync_q) begin
               fuse_high_q[`FH_SERIAL_PROG_ENABLE] <= fuse_high_q[`FH_SERIAL_PROG_ENABLE];
            end
         end
         if (wr_fuse_low && fuse_wr_ok) begin
            fuse_low_q <= pwdata[7:0];
         end
      end
   end

   // Lock byte: writes may only program bits, chip erase clears them all
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_q <= `LOCK_DEFAULT;
      end else if (erase_cmd) begin
         lock_q <= `LOCK_DEFAULT;
      end else if (wr_en && (paddr == `OFS_LOCK) && in_prog) begin
         lock_q <= lock_q & pwdata[7:0];
      end
   end

   // Active fuse copy, caught at power-up, mode entry and mode exit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_up_q <= 1'b1;
      end else begin
         power_up_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fuse_high_act_q <= `FUSE_HIGH_DEFAULT;
         fuse_low_act_q <= `FUSE_LOW_DEFAULT;
      end else begin
         if (power_up_q || state_q == ST_ENTER || state_q == ST_EXIT) begin
            fuse_high_act_q <= fuse_high_q;
            fuse_low_act_q <= fuse_low_q;
         end
         // The preserve fuse bypasses the deferral so an erase in this session honours it
         fuse_high_act_q[`FH_EEPROM_PRESERVE] <= fuse_high_q[`FH_EEPROM_PRESERVE];
      end
   end

   assign reset_pin_disable = fuse_high_act_q[`FH_RESET_PIN_DISABLE];
   assign watchdog_forced_on = fuse_high_act_q[`FH_WATCHDOG_FORCED_ON];
   assign serial_prog_enable = fuse_high_act_q[`FH_SERIAL_PROG_ENABLE];
   assign oscillator_option = fuse_high_act_q[`FH_OSCILLATOR_OPTION];
   assign eeprom_preserve = fuse_high_act_q[`FH_EEPROM_PRESERVE];
   assign boot_size_hi = fuse_high_act_q[`FH_BOOT_SIZE_HI];
   assign boot_size_lo = fuse_high_act_q[`FH_BOOT_SIZE_LO];
   assign reset_vector_select = fuse_high_act_q[`FH_RESET_VECTOR_SELECT];
   assign brownout_level = fuse_low_act_q[`FL_BROWNOUT_LEVEL];
   assign brownout_enable = fuse_low_act_q[`FL_BROWNOUT_ENABLE];
   assign startup_time_hi = fuse_low_act_q[`FL_STARTUP_TIME_HI];
   assign startup_time_lo = fuse_low_act_q[`FL_STARTUP_TIME_LO];
   assign clock_source_select = fuse_low_act_q[`FL_CLOCK_SOURCE_HI:`FL_CLOCK_SOURCE_LO];

   // Chip erase strobes; EEPROM is spared while the preserve fuse is programmed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chip_erase_flash <= 1'b0;
         chip_erase_eeprom <= 1'b0;
      end else begin
         chip_erase_flash <= erase_cmd;
         chip_erase_eeprom <= erase_cmd && fuse_high_q[`FH_EEPROM_PRESERVE];
      end
   end

   // Signature row address and oscillator trim
   logic [1:0] sig_addr_q;
   logic [7:0] sig_byte;
   logic [7:0] cal_byte;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sig_addr_q <= 2'h0;
      end else if (wr_en && (paddr == `OFS_SIG_ADDR)) begin
         sig_addr_q <= pwdata[1:0];
      end
   end

   // Identification bytes ignore every lock bit
   always_comb begin
      case (sig_addr_q)
         2'h0: sig_byte = SIG_BYTE0;
         2'h1: sig_byte = SIG_BYTE1;
         `SIG_LAST_ADDR: sig_byte = SIG_BYTE2;
         default: sig_byte = 8'h00;
      endcase
      case (sig_addr_q)
         2'h0: cal_byte = CAL_1MHZ;
         2'h1: cal_byte = CAL_2MHZ;
         2'h2: cal_byte = CAL_4MHZ;
         default: cal_byte = CAL_8MHZ;
      endcase
   end

   // Reset loads the 1 MHz value; software loads any other one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oscillator_trim_register <= CAL_1MHZ;
      end else if (wr_en && (paddr == `OFS_OSC_TRIM)) begin
         oscillator_trim_register <= pwdata[7:0];
      end
   end

   // APB read mux
   logic [31:0] rd_data;
   logic [7:0] fuse_high_view;

   // Serial path sees the serial enable fuse as unprogrammed
   assign fuse_high_view = serial_sync_q ? (fuse_high_q | (8'h01 << `FH_SERIAL_PROG_ENABLE)) : fuse_high_q;

   always_comb begin
      rd_data = 32'h0000_0000;
      case (paddr)
         `OFS_FUSE_CONFIG_HIGH: rd_data[7:0] = fuse_high_view;
         `OFS_FUSE_CONFIG_LOW: rd_data[7:0] = fuse_low_q;
         `OFS_LOCK: rd_data[7:0] = lock_q;
         `OFS_SIG_ADDR: rd_data[1:0] = sig_addr_q;
         `OFS_SIG_DATA: rd_data[15:0] = {cal_byte, sig_byte};
         `OFS_OSC_TRIM: rd_data[7:0] = oscillator_trim_register;
         `OFS_STATUS: rd_data[20:0] = {serial_sync_q, in_prog, state_q, fuse_low_act_q, fuse_high_act_q, 1'b0};
         default: rd_data = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= access;
         pslverr <= access && (!mapped || fuse_refused);
         if (rd_en) begin
            prdata <= mapped ? rd_data : 32'h0000_0000;
         end
      end
   end

   // Boot section bounds from the active boot size
   logic [11:0] boot_start;
   always_comb begin
      case ({boot_size_hi, boot_size_lo})
         2'b11: boot_start = `BOOT_START_SZ3;
         2'b10: boot_start = `BOOT_START_SZ2;
         2'b01: boot_start = `BOOT_START_SZ1;
         default: boot_start = `BOOT_START_SZ0;
      endcase
   end

   logic pc_in_boot;
   logic target_in_boot;
   logic boot_write_locked;
   logic boot_read_locked;
   assign pc_in_boot = cpu_pc >= boot_start;
   assign target_in_boot = cpu_target_addr >= boot_start;
   // Boot writes stop whenever the low lock is programmed, app reads of boot whenever the high lock is
   assign boot_write_locked = !lock_q[`LK_BOOT_LOCK_LO];
   assign boot_read_locked = !lock_q[`LK_BOOT_LOCK_HI];

   // CPU access answers one cycle after the request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         self_program_write_done <= 1'b0;
         self_program_write_ok <= 1'b0;
         program_memory_read_done <= 1'b0;
         program_memory_read_ok <= 1'b0;
         irq_block <= 1'b0;
      end else begin
         self_program_write_done <= cpu_spm_req;
         self_program_write_ok <= cpu_spm_req && !(target_in_boot && boot_write_locked);
         program_memory_read_done <= cpu_lpm_req;
         program_memory_read_ok <= cpu_lpm_req && !(target_in_boot && !pc_in_boot && boot_read_locked);
         irq_block <= boot_read_locked && !cpu_vectors_in_boot && pc_in_boot;
      end
   end

   // Page split of flash and EEPROM addresses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_in_page_index <= 5'h00;
         page_index <= 7'h00;
         eeprom_byte_index <= 2'h0;
         eeprom_page_index <= 7'h00;
      end else begin
         word_in_page_index <= flash_addr[`FLASH_WORD_MSB:0];
         page_index <= flash_addr[`FLASH_ADDR_MSB:`FLASH_PAGE_LSB];
         eeprom_byte_index <= eeprom_address[`EE_BYTE_MSB:0];
         eeprom_page_index <= eeprom_address[`EE_ADDR_MSB:`EE_PAGE_LSB];
      end
   end

endmodule : nvm_lock_fuse_config

// ---- nvm_lock_fuse_config_props.sv ----
// Checker for the fuse and lock block: APB timing, CPU gating, reset trim load, page splits.
// Assumes it is bound to nvm_lock_fuse_config and sees only its ports.
`timescale 1ns/1ns
`include "nvm_lock_fuse_config_regs.svh"
module nvm_lock_fuse_config_chk #(
   parameter logic [7:0] CAL_1MHZ = 8'h80
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [11:0] cpu_pc,
   input wire logic [11:0] cpu_target_addr,
   input wire logic cpu_spm_req,
   input wire logic cpu_lpm_req,
   input wire logic cpu_vectors_in_boot,
   input wire logic self_program_write_done,
   input wire logic self_program_write_ok,
   input wire logic program_memory_read_done,
   input wire logic program_memory_read_ok,
   input wire logic irq_block,
   input wire logic [7:0] oscillator_trim_register,
   input wire logic boot_size_hi,
   input wire logic boot_size_lo,
   input wire logic [11:0] flash_addr,
   input wire logic [8:0] eeprom_address,
   input wire logic [4:0] word_in_page_index,
   input wire logic [6:0] page_index,
   input wire logic [1:0] eeprom_byte_index,
   input wire logic [6:0] eeprom_page_index
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [11:0] boot_start;
   always_comb begin
      case ({boot_size_hi, boot_size_lo})
         2'b11: boot_start = `BOOT_START_SZ3;
         2'b10: boot_start = `BOOT_START_SZ2;
         2'b01: boot_start = `BOOT_START_SZ1;
         default: boot_start = `BOOT_START_SZ0;
      endcase
   end
   sequence s_access;
      psel && penable && !pready;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   a_apb_one_wait: assert property (s_access |=> s_answer)
      else $error("APB answer not one wait state");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_spm_answer: assert property (1'b1 |=> self_program_write_done == $past(cpu_spm_req))
      else $error("write answer not one cycle after request");
   a_app_write_open: assert property (
      cpu_spm_req && cpu_target_addr < boot_start |=> self_program_write_done && self_program_write_ok)
      else $error("application write refused");
   a_boot_read_own: assert property (
      cpu_lpm_req && (cpu_target_addr < boot_start || cpu_pc >= boot_start)
      |=> program_memory_read_done && program_memory_read_ok)
      else $error("permitted read refused");
   a_irq_app_only: assert property ((cpu_pc < boot_start || cpu_vectors_in_boot) |=> !irq_block)
      else $error("interrupts masked outside boot section");
   a_trim_on_reset: assert property ($rose(presetn) |-> oscillator_trim_register == CAL_1MHZ)
      else $error("trim not loaded at reset");
   a_flash_page_split: assert property (1'b1 |=> {page_index, word_in_page_index} == $past(flash_addr))
      else $error("flash page split wrong");
   a_eeprom_page_split: assert property (
      1'b1 |=> {eeprom_page_index, eeprom_byte_index} == $past(eeprom_address))
      else $error("eeprom page split wrong");
endmodule : nvm_lock_fuse_config_chk

bind nvm_lock_fuse_config nvm_lock_fuse_config_chk #(.CAL_1MHZ(CAL_1MHZ)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .cpu_pc(cpu_pc), .cpu_target_addr(cpu_target_addr), .cpu_spm_req(cpu_spm_req), .cpu_lpm_req(cpu_lpm_req),
   .cpu_vectors_in_boot(cpu_vectors_in_boot), .self_program_write_done(self_program_write_done),
   .self_program_write_ok(self_program_write_ok), .program_memory_read_done(program_memory_read_done),
   .program_memory_read_ok(program_memory_read_ok), .irq_block(irq_block),
   .oscillator_trim_register(oscillator_trim_register), .boot_size_hi(boot_size_hi), .boot_size_lo(boot_size_lo),
   .flash_addr(flash_addr), .eeprom_address(eeprom_address), .word_in_page_index(word_in_page_index),
   .page_index(page_index), .eeprom_byte_index(eeprom_byte_index), .eeprom_page_index(eeprom_page_index));

// ---- prog_model.sv ----
// External programmer model: drives the programming mode and path select pins.
// Assumes the bench calls its tasks and shares the device clock.
`timescale 1ns/1ns
module prog_model (
   input wire logic pclk,
   input wire logic reset_pin_disable,
   output logic prog_mode_pin,
   output logic prog_serial_pin
);
   initial begin
      prog_mode_pin = 1'b0;
      prog_serial_pin = 1'b0;
   end
   // Serial entry only while the reset pin still works; else fall back to parallel
   task automatic enter(input logic serial);
      @(posedge pclk);
      prog_serial_pin <= serial && reset_pin_disable;
      prog_mode_pin <= 1'b1;
      repeat (6) @(posedge pclk);
   endtask : enter
   task automatic leave();
      @(posedge pclk);
      prog_mode_pin <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask : leave
endmodule : prog_model

// ---- tb_top.sv ----
// Self-checking bench for the fuse and lock block: APB master, CPU strobes, programmer model.
// Assumes design, header, checker and programmer model are compiled first.
`timescale 1ns/1ns
`include "nvm_lock_fuse_config_regs.svh"
module tb_top;
   // Identification and calibration values are arbitrary
   localparam logic [7:0] SG [4] = '{8'h5A, 8'hA5, 8'h3C, 8'h00};
   localparam logic [7:0] CL [4] = '{8'h41, 8'h42, 8'h44, 8'h48};
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0, cpu_pc = '0, cpu_target_addr = '0, flash_addr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic cpu_spm_req = 1'b0, cpu_lpm_req = 1'b0, cpu_vectors_in_boot = 1'b0;
   logic [8:0] eeprom_address = '0;
   logic pready, pslverr, mode_pin, serial_pin, spm_done, spm_ok, lpm_done, lpm_ok, irq_block, ce_f, ce_e;
   logic [7:0] trim, fh_act, fl_act;
   logic [4:0] wip;
   logic [6:0] pg, eepg;
   logic [1:0] eeb;
   int num_errors = 0, n_compared = 0, n_ce_f = 0, n_ce_e = 0;
   always #20 pclk = ~pclk;
   always @(posedge pclk) begin
      if (ce_f === 1'b1) n_ce_f++;
      if (ce_e === 1'b1) n_ce_e++;
   end
   nvm_lock_fuse_config #(.SIG_BYTE0(SG[0]), .SIG_BYTE1(SG[1]), .SIG_BYTE2(SG[2]), .CAL_1MHZ(CL[0]),
      .CAL_2MHZ(CL[1]), .CAL_4MHZ(CL[2]), .CAL_8MHZ(CL[3])) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .prog_mode_pin(mode_pin),
      .prog_serial_pin(serial_pin), .cpu_pc(cpu_pc), .cpu_target_addr(cpu_target_addr),
      .cpu_spm_req(cpu_spm_req), .cpu_lpm_req(cpu_lpm_req), .cpu_vectors_in_boot(cpu_vectors_in_boot),
      .self_program_write_done(spm_done), .self_program_write_ok(spm_ok),
      .program_memory_read_done(lpm_done), .program_memory_read_ok(lpm_ok), .irq_block(irq_block),
      .chip_erase_flash(ce_f), .chip_erase_eeprom(ce_e), .oscillator_trim_register(trim),
      .reset_pin_disable(fh_act[7]), .watchdog_forced_on(fh_act[6]), .serial_prog_enable(fh_act[5]),
      .oscillator_option(fh_act[4]), .eeprom_preserve(fh_act[3]), .boot_size_hi(fh_act[2]),
      .boot_size_lo(fh_act[1]), .reset_vector_select(fh_act[0]), .brownout_level(fl_act[7]),
      .brownout_enable(fl_act[6]), .startup_time_hi(fl_act[5]), .startup_time_lo(fl_act[4]),
      .clock_source_select(fl_act[3:0]), .flash_addr(flash_addr), .eeprom_address(eeprom_address),
      .word_in_page_index(wip), .page_index(pg), .eeprom_byte_index(eeb), .eeprom_page_index(eepg));
   prog_model u_prog (.pclk(pclk), .reset_pin_disable(fh_act[7]), .prog_mode_pin(mode_pin),
      .prog_serial_pin(serial_pin));
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ee,
      input logic [31:0] exp);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      chk("apb_ready", 32'h0000_0001, {31'h0, pready});
      chk("apb_error", {31'h0, ee}, {31'h0, pslverr});
      if (!w) chk("read_data", exp, prdata);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic cpu_op(input logic [11:0] pc, input logic [11:0] tgt, input logic vb, input logic [3:0] exp);
      @(posedge pclk);
      cpu_pc <= pc;
      cpu_target_addr <= tgt;
      cpu_vectors_in_boot <= vb;
      cpu_spm_req <= 1'b1;
      cpu_lpm_req <= 1'b1;
      @(posedge pclk);
      cpu_spm_req <= 1'b0;
      cpu_lpm_req <= 1'b0;
      @(posedge pclk);
      chk("cpu_result", {28'h0, exp}, {28'h0, spm_done & spm_ok, lpm_done & lpm_ok, irq_block, spm_done & lpm_done});
   endtask : cpu_op
   task automatic do_reset();
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
   endtask : do_reset
   task automatic t_sig();
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `OFS_SIG_ADDR, 32'(i), 1'b0, '0);
         apb(1'b0, `OFS_SIG_DATA, '0, 1'b0, {16'h0, CL[i], SG[i]});
      end
   endtask : t_sig
   task automatic t_defaults();
      do_reset();
      chk("fuse_high_active", 32'h0000_00D9, {24'h0, fh_act});
      chk("fuse_low_active", 32'h0000_00E1, {24'h0, fl_act});
      chk("trim_reset", {24'h0, CL[0]}, {24'h0, trim});
      apb(1'b0, `OFS_FUSE_CONFIG_HIGH, '0, 1'b0, 32'h0000_00D9);
      apb(1'b0, `OFS_FUSE_CONFIG_LOW, '0, 1'b0, 32'h0000_00E1);
      apb(1'b0, `OFS_LOCK, '0, 1'b0, 32'h0000_00FF);
      apb(1'b0, 12'h020, '0, 1'b1, 32'h0000_0000);
      apb(1'b1, `OFS_OSC_TRIM, {24'h0, CL[3]}, 1'b0, '0);
      chk("trim_loaded", {24'h0, CL[3]}, {24'h0, trim});
      flash_addr <= 12'hABC;
      eeprom_address <= 9'h1F7;
      repeat (2) @(posedge pclk);
      chk("page_split", {11'h0, 7'h55, 5'h1C, 7'h7D, 2'h3}, {11'h0, pg, wip, eepg, eeb});
   endtask : t_defaults
   task automatic t_fuse();
      do_reset();
      u_prog.enter(1'b0);
      apb(1'b1, `OFS_FUSE_CONFIG_HIGH, 32'h0000_0097, 1'b0, '0);
      @(posedge pclk);
      chk("fuse_high_in_mode", 32'h0000_00D1, {24'h0, fh_act});
      apb(1'b1, `OFS_COMMAND, 32'h0000_0001, 1'b0, '0);
      apb(1'b0, `OFS_FUSE_CONFIG_HIGH, '0, 1'b0, 32'h0000_0097);
      chk("erase_pulses", 32'h0000_0100, {16'h0, 8'(n_ce_f), 8'(n_ce_e)});
      apb(1'b1, `OFS_LOCK, 32'h0000_00CE, 1'b0, '0);
      apb(1'b1, `OFS_FUSE_CONFIG_LOW, 32'h0000_0000, 1'b1, '0);
      apb(1'b0, `OFS_FUSE_CONFIG_LOW, '0, 1'b0, 32'h0000_00E1);
      u_prog.leave();
      chk("fuse_high_latched", 32'h0000_0097, {24'h0, fh_act});
      // Smallest boot section now starts the boot area high in flash
      cpu_op(12'h100, 12'hF00, 1'b0, 4'hD);
      cpu_op(12'h100, 12'hF90, 1'b0, 4'h1);
      u_prog.enter(1'b1);
      apb(1'b0, `OFS_FUSE_CONFIG_HIGH, '0, 1'b0, 32'h0000_00B7);
      t_sig();
      u_prog.leave();
   endtask : t_fuse
   task automatic t_locks();
      logic [1:0] codes [4] = '{2'b11, 2'b10, 2'b00, 2'b01};
      do_reset();
      u_prog.enter(1'b0);
      for (int i = 0; i < 4; i++) begin
         if (i == 3) apb(1'b1, `OFS_COMMAND, 32'h0000_0001, 1'b0, '0);
         apb(1'b1, `OFS_LOCK, {24'h0, 2'b11, codes[i], 4'hF}, 1'b0, '0);
         cpu_op(12'h100, 12'h100, 1'b0, 4'hD);
         cpu_op(12'h100, 12'hC10, 1'b0, {codes[i][0], codes[i][1], 2'b01});
         cpu_op(12'hC20, 12'hC10, 1'b0, {codes[i][0], 1'b1, ~codes[i][1], 1'b1});
         cpu_op(12'hC20, 12'hC10, 1'b1, {codes[i][0], 1'b1, 2'b01});
      end
      u_prog.leave();
   endtask : t_locks
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      wrap_up();
   end
   initial begin
      t_defaults();
      t_fuse();
      t_locks();
      wrap_up();
   end
endmodule : tb_top
